// ### logic/tpm_pkg.sv
// constants for the 16-bit timer with interval, pwm and pulse generator modes
`default_nettype none
package tpm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_OUTCTL = 8'h08;
  localparam logic [7:0] OFS_CMP0 = 8'h0c;
  localparam logic [7:0] OFS_CMP1 = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_OSCMODE = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  // field positions
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam int OVF_BIT = 0;
  localparam int CLKSEL_LSB = 4;
  localparam int CLKSEL_MSB = 6;
  localparam int OUT_EN_BIT = 0;
  localparam int ACT_LVL_BIT = 1;
  localparam int INV1_BIT = 4;
  localparam int MCS_BIT = 0;
  localparam int IRQ_CMP0_BIT = 0;
  localparam int IRQ_CMP1_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int PWM_FRAC_W = 6;
  localparam int PWM_BASE_W = 8;
  localparam int PWM_LSB = 2;
  // mode field codes
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_PWM = 3'h1;
  localparam logic [2:0] MODE_CLR_A = 3'h6;
  localparam logic [2:0] MODE_CLR_B = 3'h7;
  // count clock select codes
  localparam logic [2:0] CLK_PIN = 3'h0;
  localparam logic [2:0] CLK_FX = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h4;
  localparam logic [2:0] CLK_WATCH = 3'h7;
  // reset values and counter maximum
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage : tpm_pkg
`default_nettype wire

// ### logic/tpm_clksel.sv
// count clock source selection and prescaler, yields one-cycle count ticks
`default_nettype none
module tpm_clksel (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [2:0] sel, // count clock select code
  input wire logic main_clock_div_select, // main clock divide select
  input wire logic timer_input_pin, // external count input
  input wire logic watch_tick_pin, // watch timer output
  output logic tick // one count clock event
);
  logic [2:0] pin_sync_r;
  logic [2:0] wt_sync_r;
  logic [2:0] pre_r;
  logic [2:0] pre_mask;
  logic div_ok;
  logic tick_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_r <= 3'h0;
      wt_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], timer_input_pin};
      wt_sync_r <= {wt_sync_r[1:0], watch_tick_pin};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  always_comb begin
    div_ok = 1'b0;
    pre_mask = 3'h0;
    tick_nxt = 1'b0;
    if (sel >= tpm_pkg::CLK_FX && sel <= tpm_pkg::CLK_DIV8) begin
      // halve per code step; fx rate is prohibited when mcs is set
      div_ok = !(main_clock_div_select && sel == tpm_pkg::CLK_FX);
      pre_mask = 3'(({3'h0, 1'b1} << (sel - (main_clock_div_select ? 3'h2 : 3'h1))) - 4'h1);
    end
    unique case (sel)
      tpm_pkg::CLK_PIN: tick_nxt = pin_sync_r[1] & ~pin_sync_r[2];
      tpm_pkg::CLK_WATCH: tick_nxt = wt_sync_r[1] & ~wt_sync_r[2];
      default: tick_nxt = div_ok && ((pre_r & pre_mask) == pre_mask);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_nxt;
    end
  end
endmodule : tpm_clksel
`default_nettype wire

// ### logic/tpm_timer.sv
// 16-bit timer with interval, 14-bit pwm and pulse generator output, apb slave
//
// Contract
// - interval mode: match clears counter, raises interrupt
// - count clock from select bits 4 to 6
// - select codes: pin, divided clock, watch
// - pwm width from upper 14 compare bits
// - pwm active level from output control bit1
// - 256-clock basic cycle, 16384-clock sub-cycle
// - pin driven only while output enabled
// - pulse generator: period cmp0, width cmp1
// - nonzero mode starts, zero stops and clears
// - overflow flag on ffff to 0000 roll
// - active level: 0 high, 1 low
`default_nettype none
module tpm_timer (
  input wire logic pclk, // apb clock, 20 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic timer_input_pin, // external count input
  input wire logic watch_tick_pin, // watch timer output
  output logic timer_output_pin, // timer output level
  output logic timer_output_pin_oe, // timer output drive enable
  output logic compare_match_irq // level interrupt
);
  localparam int IRQW = tpm_pkg::IRQ_W;
  logic [2:0] mode_r;
  logic [2:0] clksel_r;
  logic toe_r;
  logic act_lvl_r;
  logic inv1_r;
  logic mcs_r;
  logic [15:0] cmp0_r;
  logic [15:0] cmp1_r;
  logic [15:0] count_r;
  logic [IRQW-1:0] stat_r;
  logic [IRQW-1:0] mask_r;
  logic ff_r;
  logic tick;
  logic wr_en;
  logic setup;
  logic hit;
  logic [31:0] rd_nxt;
  logic running;
  logic pwm_mode;
  logic clr_mode;
  logic match0;
  logic match1;
  logic roll;
  logic [IRQW-1:0] evt;
  logic [tpm_pkg::PWM_BASE_W:0] pwm_width;
  logic [tpm_pkg::PWM_FRAC_W-1:0] sub_rev;
  logic pwm_act;

  ////////////////////////////////////////////////////////////////////////
  // count clock

  tpm_clksel u_clksel (
    .pclk(pclk),
    .presetn(presetn),
    .sel(clksel_r),
    .main_clock_div_select(mcs_r),
    .timer_input_pin(timer_input_pin),
    .watch_tick_pin(watch_tick_pin),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb slave: no wait states, answer in first access cycle

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_nxt = tpm_pkg::RD_ZERO;
    unique case (paddr)
      tpm_pkg::OFS_MODE: begin
        rd_nxt[tpm_pkg::MODE_MSB:tpm_pkg::MODE_LSB] = mode_r;
        rd_nxt[tpm_pkg::OVF_BIT] = stat_r[tpm_pkg::IRQ_OVF_BIT];
      end
      tpm_pkg::OFS_CLKSEL: rd_nxt[tpm_pkg::CLKSEL_MSB:tpm_pkg::CLKSEL_LSB] = clksel_r;
      tpm_pkg::OFS_OUTCTL: begin
        rd_nxt[tpm_pkg::OUT_EN_BIT] = toe_r;
        rd_nxt[tpm_pkg::ACT_LVL_BIT] = act_lvl_r;
        rd_nxt[tpm_pkg::INV1_BIT] = inv1_r;
      end
      tpm_pkg::OFS_CMP0: rd_nxt[15:0] = cmp0_r;
      tpm_pkg::OFS_CMP1: rd_nxt[15:0] = cmp1_r;
      tpm_pkg::OFS_COUNT: rd_nxt[15:0] = count_r;
      tpm_pkg::OFS_OSCMODE: rd_nxt[tpm_pkg::MCS_BIT] = mcs_r;
      tpm_pkg::OFS_IRQ_STAT: rd_nxt[IRQW-1:0] = stat_r;
      tpm_pkg::OFS_IRQ_MASK: rd_nxt[IRQW-1:0] = mask_r;
      default: hit = 1'b0;
    endcase
  end

  // no wait states: ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= tpm_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? tpm_pkg::RD_ZERO : rd_nxt;
      pslverr <= !hit;
    end else begin
      prdata <= tpm_pkg::RD_ZERO;
      pslverr <= 1'b0;
    end
  end

  // mode field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= tpm_pkg::MODE_STOP;
    end else if (wr_en && paddr == tpm_pkg::OFS_MODE) begin
      mode_r <= pwdata[tpm_pkg::MODE_MSB:tpm_pkg::MODE_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clksel_r <= tpm_pkg::CLK_PIN;
    end else if (wr_en && paddr == tpm_pkg::OFS_CLKSEL) begin
      clksel_r <= pwdata[tpm_pkg::CLKSEL_MSB:tpm_pkg::CLKSEL_LSB];
    end
  end

  // main clock divide select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcs_r <= 1'b0;
    end else if (wr_en && paddr == tpm_pkg::OFS_OSCMODE) begin
      mcs_r <= pwdata[tpm_pkg::MCS_BIT];
    end
  end

  // output enable, level and toggle bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toe_r <= 1'b0;
      act_lvl_r <= 1'b0;
      inv1_r <= 1'b0;
    end else if (wr_en && paddr == tpm_pkg::OFS_OUTCTL) begin
      toe_r <= pwdata[tpm_pkg::OUT_EN_BIT];
      act_lvl_r <= pwdata[tpm_pkg::ACT_LVL_BIT];
      inv1_r <= pwdata[tpm_pkg::INV1_BIT];
    end
  end

  // period compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp0_r <= tpm_pkg::CMP_RST;
    end else if (wr_en && paddr == tpm_pkg::OFS_CMP0) begin
      cmp0_r <= pwdata[15:0];
    end
  end

  // width compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp1_r <= tpm_pkg::CMP_RST;
    end else if (wr_en && paddr == tpm_pkg::OFS_CMP1) begin
      cmp1_r <= pwdata[15:0];
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else if (wr_en && paddr == tpm_pkg::OFS_IRQ_MASK) begin
      mask_r <= pwdata[IRQW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter

  assign running = (mode_r != tpm_pkg::MODE_STOP);
  assign pwm_mode = (mode_r == tpm_pkg::MODE_PWM);
  assign clr_mode = (mode_r == tpm_pkg::MODE_CLR_A) || (mode_r == tpm_pkg::MODE_CLR_B);
  assign match0 = running && !pwm_mode && tick && (count_r == cmp0_r);
  assign match1 = running && !pwm_mode && tick && (count_r == cmp1_r);
  assign roll = running && tick && (count_r == tpm_pkg::CNT_MAX);

  // start on nonzero mode, stop clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= tpm_pkg::CMP_RST;
    end else if (!running) begin
      count_r <= tpm_pkg::CMP_RST;
    end else if (tick) begin
      // clear on match and keep counting; gives cmp0+1 ticks
      if (clr_mode && count_r == cmp0_r) begin
        count_r <= tpm_pkg::CMP_RST;
      end else begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events and interrupt

  always_comb begin
    evt = '0;
    evt[tpm_pkg::IRQ_CMP0_BIT] = match0;
    evt[tpm_pkg::IRQ_CMP1_BIT] = match1;
    evt[tpm_pkg::IRQ_OVF_BIT] = roll;
  end

  // set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (wr_en && paddr == tpm_pkg::OFS_IRQ_STAT) begin
      stat_r <= (stat_r & ~pwdata[IRQW-1:0]) | evt;
    end else if (wr_en && paddr == tpm_pkg::OFS_MODE) begin
      stat_r <= (stat_r & ~(IRQW'(!pwdata[tpm_pkg::OVF_BIT]) << tpm_pkg::IRQ_OVF_BIT)) | evt;
    end else begin
      stat_r <= stat_r | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_irq <= 1'b0;
    end else begin
      compare_match_irq <= |((stat_r | evt) & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm: base width per 256 ticks, extra tick spread over 64 basic cycles

  // sub-cycle index bit-reversed to spread extras
  for (genvar i = 0; i < tpm_pkg::PWM_FRAC_W; i++) begin : g_sub_rev
    assign sub_rev[i] = count_r[tpm_pkg::PWM_BASE_W + tpm_pkg::PWM_FRAC_W - 1 - i];
  end

  // width from upper 14 bits; average cmp0/65536
  always_comb begin
    pwm_width = {1'b0, cmp0_r[15:tpm_pkg::PWM_LSB + tpm_pkg::PWM_FRAC_W]};
    if (sub_rev < cmp0_r[tpm_pkg::PWM_LSB + tpm_pkg::PWM_FRAC_W - 1:tpm_pkg::PWM_LSB]) begin
      pwm_width = pwm_width + 9'h001;
    end
    pwm_act = {1'b0, count_r[tpm_pkg::PWM_BASE_W-1:0]} < pwm_width;
  end

  ////////////////////////////////////////////////////////////////////////
  // output flip-flop and pin

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_r <= 1'b0;
    end else if (pwm_mode) begin
      // polarity: 0 active high, 1 active low
      ff_r <= pwm_act ^ act_lvl_r;
    end else if (running) begin
      // toggle at period match when level bit1 set, at width match when bit4 set
      ff_r <= ff_r ^ ((match0 && act_lvl_r) ^ (match1 && inv1_r));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin <= 1'b0;
      timer_output_pin_oe <= 1'b0;
    end else begin
      timer_output_pin <= toe_r & ff_r;
      timer_output_pin_oe <= toe_r;
    end
  end
endmodule : tpm_timer
`default_nettype wire

// ### logic/README_unused.sv
`default_nettype none
`default_nettype wire

// ### verif/tpm_timer_monitor.sv
// port checker for the timer block
`default_nettype none
module tpm_timer_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic timer_output_pin, // output level
  input wire logic timer_output_pin_oe, // output enable
  input wire logic compare_match_irq // interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr;
    psel && penable && pready && pwrite;
  endsequence
  sequence s_oe_wr;
    psel && penable && pready && pwrite && paddr == tpm_pkg::OFS_OUTCTL;
  endsequence
  property p_oe;
    s_oe_wr |-> ##2 timer_output_pin_oe == $past(pwdata[tpm_pkg::OUT_EN_BIT], 2);
  endproperty
  a_wr_answer_zero: assert property (s_wr |-> prdata == 32'h0000_0000) else $error("read data on write answer");
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
  a_pin_low_disabled: assert property (!timer_output_pin_oe |-> !timer_output_pin) else $error("pin set while disabled");
  a_oe_follows_write: assert property (p_oe) else $error("enable not following write");
  a_oe_needs_write: assert property ($changed(timer_output_pin_oe) |->
    $past(psel && penable && pready && pwrite && paddr == tpm_pkg::OFS_OUTCTL, 2))
    else $error("enable changed without write");
  a_irq_falls_write: assert property ($fell(compare_match_irq) |-> $past(psel && penable && pwrite) ||
    $past(psel && penable && pwrite, 2)) else $error("irq dropped without write");
endmodule : tpm_timer_monitor
`default_nettype wire

// ### verif/tpm_timer_tb.sv
// self-checking bench for the timer block
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module tpm_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, tpin, wpin, pin, oe, irq, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cs [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h2};
  int ms [7] = '{0, 0, 0, 0, 0, 0, 1};
  int dv [7] = '{8, 1, 2, 4, 8, 8, 1};
  int num_errors = 0, checked = 0, cyc = 0, t1, t2, hi;
  tpm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(tpin),
    .watch_tick_pin(wpin), .timer_output_pin(pin), .timer_output_pin_oe(oe), .compare_match_irq(irq));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // pin sources: rising edge every 8 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) begin
      tpin <= ~tpin;
      wpin <= ~wpin;
    end
    if (cyc == 110000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic wirq(output int t);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 70000) begin
      @(posedge pclk);
      n++;
    end
    t = cyc;
    `CHK(irq, 1'b1)
  endtask : wirq
  task automatic cnt(input int len, input logic lv, output int n);
    n = 0;
    repeat (len) begin
      @(posedge pclk);
      if (pin === lv) n++;
    end
  endtask : cnt
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    {presetn, psel, penable, pwrite, tpin, wpin} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0000_0000)
    end
    acc(1'b0, 8'h24, 32'h0);
    `CHK({e, rd}, {1'b1, 32'h0000_0000})
    for (int i = 0; i < 7; i++) begin
      wr(tpm_pkg::OFS_MODE, 32'h0);
      wr(tpm_pkg::OFS_CLKSEL, 32'(cs[i]) << 4);
      wr(tpm_pkg::OFS_OSCMODE, 32'(ms[i]));
      wr(tpm_pkg::OFS_CMP0, 32'h9);
      wr(tpm_pkg::OFS_IRQ_MASK, 32'h1);
      wr(tpm_pkg::OFS_IRQ_STAT, 32'h7);
      wr(tpm_pkg::OFS_MODE, 32'h0c);
      wirq(t1);
      wr(tpm_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      wirq(t2);
      `CHK(t2 - t1, 10 * dv[i])
    end
    wr(tpm_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (100) @(posedge pclk);
    acc(1'b0, tpm_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK({irq, rd[0]}, 2'b01)
    wr(tpm_pkg::OFS_MODE, 32'h0);
    acc(1'b0, tpm_pkg::OFS_COUNT, 32'h0);
    `CHK(rd, 32'h0000_0000)
    wr(tpm_pkg::OFS_CMP1, 32'h3);
    wr(tpm_pkg::OFS_OUTCTL, 32'h13);
    wr(tpm_pkg::OFS_MODE, 32'h0c);
    repeat (20) @(posedge pclk);
    cnt(100, 1'b1, hi);
    `CHK(hi, 60)
    wr(tpm_pkg::OFS_MODE, 32'h0);
    wr(tpm_pkg::OFS_CMP0, 32'hffff);
    wr(tpm_pkg::OFS_IRQ_STAT, 32'h7);
    wr(tpm_pkg::OFS_IRQ_MASK, 32'h4);
    wr(tpm_pkg::OFS_MODE, 32'h0e);
    wirq(t1);
    acc(1'b0, tpm_pkg::OFS_MODE, 32'h0);
    `CHK(rd[0], 1'b1)
    wr(tpm_pkg::OFS_MODE, 32'h0);
    wr(tpm_pkg::OFS_MODE, 32'h02);
    wr(tpm_pkg::OFS_CMP0, 32'h4104);
    wr(tpm_pkg::OFS_OUTCTL, 32'h1);
    repeat (4) @(posedge pclk);
    cnt(16384, 1'b1, hi);
    `CHK(hi, 4161)
    wr(tpm_pkg::OFS_OUTCTL, 32'h3);
    repeat (4) @(posedge pclk);
    cnt(16384, 1'b0, hi);
    `CHK(hi, 4161)
    wr(tpm_pkg::OFS_OUTCTL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK({oe, pin}, 2'b00)
    wrap_up();
  end
endmodule : tpm_timer_tb
bind tpm_timer tpm_timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe),
  .compare_match_irq(compare_match_irq));
`default_nettype wire
